// file: core/dsadc_seq.sv
`timescale 1ns/1ps
module dsadc_seq #(
    parameter int acc_width = dsadc_pkg::acc_width
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire dsadc_pkg::dsadc_apb_req_type apb_req,
    output dsadc_pkg::dsadc_apb_rsp_type apb_rsp,
    input wire logic mod_bit,
    input wire logic start_trig,
    output logic conv_done,
    output logic mux_select
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        dsadc_pkg::dsadc_state_type fsm;
        logic [31:0] ctrl;
        logic [15:0] decim;
        logic [15:0] tick;
        logic [2:0] conv_left;
        logic [2:0] settle;
        logic done;
        logic overrun;
        logic valid;
        logic [31:0] result;
        logic [31:0] prdata;
        logic [2:0] trig_sync;
        logic trig_level;
        logic rd_wait;
        logic take;
        logic take_valid;
    } dsadc_seq_type;

    dsadc_seq_type state;
    dsadc_seq_type next_state;
    logic [acc_width-1:0] dec_word;
    logic dec_clear;
    logic dec_dump;
    logic wr_acc;
    logic rd_acc;
    logic trig_rise;
    logic start_req;
    logic mux_change;
    logic [31:0] aligned;
    dsadc_pkg::dsadc_mode_type mode;
    dsadc_pkg::dsadc_res_type res;

    // Result scaled to the selected resolution: the filter gain is the
    // ratio to the fourth, so the top bits of that range are kept.
    // Limitation: a ratio that is no power of two rounds the gain down,
    // and an input held at full scale wraps to zero unless the gain is narrower than the result.
    function automatic logic [31:0] scale_word(
        input logic [acc_width-1:0] w,
        input dsadc_pkg::dsadc_res_type r,
        input logic [15:0] d
    );
        logic [31:0] v;
        int gain_bits;
        int keep;
        v = w[31:0];
        gain_bits = 0;
        keep = 0;
        for (int i = 0; i < 16; i++) begin
            if (d[i]) begin
                gain_bits = 4 * i;
            end
        end
        unique case (r)
            dsadc_pkg::dsadc_res8_type_e: keep = 8;
            dsadc_pkg::dsadc_res12_type_e: keep = 12;
            dsadc_pkg::dsadc_res16_type_e: keep = 16;
            dsadc_pkg::dsadc_res20_type_e: keep = 20;
        endcase
        if (gain_bits > keep) begin
            v = v >> (gain_bits - keep);
        end
        scale_word = v & ((32'h1 << keep) - 32'h1);
    endfunction : scale_word

    function automatic logic is_addr(
        input logic [31:0] a,
        input logic [7:0] off
    );
        is_addr = (a[7:0] == off) && (a[31:8] == 24'h0);
    endfunction : is_addr

    dsadc_sinc4 #(
        .width(acc_width)
    ) u_sinc (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .clear(dec_clear),
        .bit_in(mod_bit),
        .dump(dec_dump),
        .word(dec_word)
    );

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_acc = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    assign mode = dsadc_pkg::dsadc_mode_type'(
        state.ctrl[dsadc_pkg::ctrl_mode_lsb +: 2]);
    assign res = dsadc_pkg::dsadc_res_type'(
        state.ctrl[dsadc_pkg::ctrl_res_lsb +: 2]);
    // Trigger counts once stages two and three agree on a rise
    assign trig_rise = state.trig_sync[2] && state.trig_sync[1] &&
        !state.trig_level;
    assign aligned = scale_word(dec_word, res, state.decim);
    // A write that flips the mux bit restarts the settle count
    assign mux_change = wr_acc &&
        is_addr(apb_req.paddr, dsadc_pkg::ctrl_offset) &&
        (apb_req.pwdata[dsadc_pkg::ctrl_mux_bit] !=
        state.ctrl[dsadc_pkg::ctrl_mux_bit]);

    always_comb begin
        next_state = state;
        dec_clear = 1'b0;
        dec_dump = 1'b0;
        start_req = 1'b0;
        next_state.trig_sync = {state.trig_sync[1:0], start_trig};
        if (state.trig_sync[2] == state.trig_sync[1]) begin
            next_state.trig_level = state.trig_sync[1];
        end
        next_state.ctrl[dsadc_pkg::ctrl_start_bit] = 1'b0;
        next_state.prdata = 32'h0;
        next_state.take = 1'b0;
        // Read data is latched on the first access edge, ready on the next
        next_state.rd_wait = rd_acc && !state.rd_wait;

        // Register writes; the start bit self-clears
        if (wr_acc) begin
            if (is_addr(apb_req.paddr, dsadc_pkg::ctrl_offset)) begin
                next_state.ctrl = {25'h0, apb_req.pwdata[6:0]};
                if (mux_change) begin
                    next_state.settle = dsadc_pkg::settle_count;
                end
            end
            if (is_addr(apb_req.paddr, dsadc_pkg::decim_offset)) begin
                next_state.decim = apb_req.pwdata[15:0];
            end
        end

        start_req = state.ctrl[dsadc_pkg::ctrl_start_bit] || trig_rise;

        // Conversion period ticks from the decimation ratio
        if (state.fsm != dsadc_pkg::dsadc_idle) begin
            if (state.tick == 16'h0) begin
                next_state.tick = state.decim - 16'h1;
                dec_dump = 1'b1;
            end else begin
                next_state.tick = state.tick - 16'h1;
            end
        end

        unique case (state.fsm)
            dsadc_pkg::dsadc_idle: begin
                // Continuous mode needs no trigger after the first start
                if (start_req && state.ctrl[dsadc_pkg::ctrl_enable_bit]) begin
                    dec_clear = 1'b1;
                    next_state.tick = state.decim - 16'h1;
                    next_state.conv_left = dsadc_pkg::prime_count;
                    next_state.fsm = dsadc_pkg::dsadc_prime;
                end
            end
            dsadc_pkg::dsadc_prime: begin
                if (dec_dump) begin
                    if (state.conv_left == 3'h1) begin
                        next_state.fsm = dsadc_pkg::dsadc_run;
                    end
                    next_state.conv_left = state.conv_left - 3'h1;
                end
            end
            dsadc_pkg::dsadc_run: begin
                if (dec_dump) begin
                    // Fourth conversion is the first result
                    next_state.take = 1'b1;
                    next_state.take_valid = (state.settle == 3'h0);
                    unique case (mode)
                        dsadc_pkg::dsadc_single_type_e: begin
                            next_state.fsm = dsadc_pkg::dsadc_hold;
                        end
                        dsadc_pkg::dsadc_cont_type_e: begin
                            next_state.fsm = dsadc_pkg::dsadc_run;
                        end
                        dsadc_pkg::dsadc_multi_type_e: begin
                            // Re-prime for every sample
                            dec_clear = 1'b1;
                            next_state.conv_left = dsadc_pkg::prime_count;
                            next_state.fsm = dsadc_pkg::dsadc_prime;
                        end
                        dsadc_pkg::dsadc_turbo_type_e: begin
                            // Only the 20-bit resolution skips the re-prime
                            if (res == dsadc_pkg::dsadc_res20_type_e) begin
                                next_state.fsm = dsadc_pkg::dsadc_run;
                            end else begin
                                dec_clear = 1'b1;
                                next_state.conv_left = dsadc_pkg::prime_count;
                                next_state.fsm = dsadc_pkg::dsadc_prime;
                            end
                        end
                    endcase
                end
            end
            dsadc_pkg::dsadc_hold: begin
                // Wait for the single result to be read
                if (!state.done && !state.take) begin
                    next_state.fsm = dsadc_pkg::dsadc_idle;
                end
            end
        endcase

        // Mux change counts down over following samples
        // A mux change in the same cycle keeps its full count
        if (dec_dump && state.settle != 3'h0 && !mux_change &&
            state.fsm != dsadc_pkg::dsadc_idle) begin
            next_state.settle = state.settle - 3'h1;
        end

        // ----------------------------------------------------------------
        // Result hand-over
        // ----------------------------------------------------------------
        // The filter word is registered at the dump, so it is taken one
        // edge later: a cycle of latency instead of a second output path
        if (state.take) begin
            next_state.result = aligned;
            next_state.valid = state.take_valid;
            next_state.overrun = state.overrun || state.done;
            next_state.done = 1'b1;
        end

        // Disabling drops back to idle in any mode
        if (!state.ctrl[dsadc_pkg::ctrl_enable_bit]) begin
            next_state.fsm = dsadc_pkg::dsadc_idle;
        end

        // Reading result clears done; a same-cycle new result wins
        if (rd_acc && is_addr(apb_req.paddr, dsadc_pkg::result_offset)) begin
            next_state.prdata = state.result;
            if (!state.take) begin
                next_state.done = 1'b0;
            end
        end
        if (rd_acc && is_addr(apb_req.paddr, dsadc_pkg::status_offset)) begin
            // Status is polled here instead of the done pin
            next_state.prdata = {28'h0, state.overrun,
                state.fsm != dsadc_pkg::dsadc_idle, state.valid, state.done};
            // An overrun landing in this cycle survives the clearing read
            next_state.overrun = state.take && state.done;
        end
        if (rd_acc && is_addr(apb_req.paddr, dsadc_pkg::ctrl_offset)) begin
            next_state.prdata = state.ctrl;
        end
        if (rd_acc && is_addr(apb_req.paddr, dsadc_pkg::decim_offset)) begin
            next_state.prdata = {16'h0, state.decim};
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= '0;
            state.ctrl <= dsadc_pkg::ctrl_reset;
            state.decim <= dsadc_pkg::decim_reset;
            state.fsm <= dsadc_pkg::dsadc_idle;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Read data is taken one edge later, so the access phase waits once
    always_comb begin
        apb_rsp.prdata = state.prdata;
        apb_rsp.pready = apb_req.pwrite ? ce : (state.rd_wait && ce);
        apb_rsp.pslverr = 1'b0;
    end

    assign conv_done = state.done;
    assign mux_select = state.ctrl[dsadc_pkg::ctrl_mux_bit];

endmodule : dsadc_seq

// file: core/dsadc_pkg.sv
package dsadc_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] status_offset = 8'h04;
    localparam logic [7:0] result_offset = 8'h08;
    localparam logic [7:0] decim_offset = 8'h0c;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ctrl_start_bit = 0;
    localparam int ctrl_mode_lsb = 1;
    localparam int ctrl_res_lsb = 3;
    localparam int ctrl_enable_bit = 5;
    localparam int ctrl_mux_bit = 6;
    localparam int status_done_bit = 0;
    localparam int status_valid_bit = 1;
    localparam int status_busy_bit = 2;
    localparam int status_overrun_bit = 3;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    localparam logic [15:0] decim_reset = 16'h0040;
    localparam logic [2:0] prime_count = 3'h3;
    localparam logic [2:0] settle_count = 3'h4;
    localparam int filter_order = 4;
    localparam int acc_width = 32;

    typedef enum logic [1:0] {
        dsadc_single_type_e = 2'b00,
        dsadc_multi_type_e = 2'b01,
        dsadc_cont_type_e = 2'b10,
        dsadc_turbo_type_e = 2'b11
    } dsadc_mode_type;

    // Resolution codes: 8, 12, 16 and 20 bits
    typedef enum logic [1:0] {
        dsadc_res8_type_e = 2'b00,
        dsadc_res12_type_e = 2'b01,
        dsadc_res16_type_e = 2'b10,
        dsadc_res20_type_e = 2'b11
    } dsadc_res_type;

    typedef enum logic [1:0] {
        dsadc_idle = 2'b00,
        dsadc_prime = 2'b01,
        dsadc_run = 2'b10,
        dsadc_hold = 2'b11
    } dsadc_state_type;

    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } dsadc_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dsadc_apb_rsp_type;

endpackage : dsadc_pkg

// file: core/dsadc_sinc4.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Fourth-order sinc decimator: bitstream in, words out
// ----------------------------------------------------------------
module dsadc_sinc4 #(
    parameter int width = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clear,
    input wire logic bit_in,
    input wire logic dump,
    output logic [width-1:0] word
);

    typedef struct packed {
        logic [3:0][width-1:0] integ;
        logic [3:0][width-1:0] delay;
        logic [width-1:0] word;
    } dsadc_sinc_type;

    dsadc_sinc_type state;
    dsadc_sinc_type next_state;
    logic [4:0][width-1:0] comb_chain;

    always_comb begin
        next_state = state;
        // Cascade of four integrators at the modulator rate
        next_state.integ[0] = state.integ[0] + {{(width-1){1'b0}}, bit_in};
        for (int i = 1; i < 4; i++) begin
            next_state.integ[i] = state.integ[i] + state.integ[i-1];
        end
        comb_chain[0] = state.integ[3];
        // Four comb stages at the output rate
        for (int i = 0; i < 4; i++) begin
            comb_chain[i+1] = comb_chain[i] - state.delay[i];
        end
        if (dump) begin
            for (int i = 0; i < 4; i++) begin
                next_state.delay[i] = comb_chain[i];
            end
            next_state.word = comb_chain[4];
        end
        // Clear restarts the filter but keeps the last word for the reader
        if (clear) begin
            next_state.integ = '0;
            next_state.delay = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= '0;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign word = state.word;

endmodule : dsadc_sinc4

// file: verification/dsadc_seq_props.sv
`timescale 1ns/1ps
module dsadc_seq_props #(
    parameter int acc_width = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire dsadc_pkg::dsadc_apb_req_type apb_req,
    input wire dsadc_pkg::dsadc_apb_rsp_type apb_rsp,
    input wire logic mod_bit,
    input wire logic start_trig,
    input wire logic conv_done,
    input wire logic mux_select
);
    // ----------------
    // Shadow of mode, ratio and start timing
    // ----------------
    logic trig_q;
    logic [1:0] mode;
    logic [1:0] res;
    logic [15:0] decim;
    int since;
    logic acc;
    logic wr_ok;
    logic ctrl_wr;
    logic rd_first;
    logic start_ev;
    assign acc = apb_req.psel && apb_req.penable && ce;
    assign wr_ok = acc && apb_req.pwrite && apb_rsp.pready;
    assign ctrl_wr = wr_ok && apb_req.paddr[7:0] == dsadc_pkg::ctrl_offset;
    assign rd_first = acc && !apb_req.pwrite && !apb_rsp.pready
        && apb_req.paddr[7:0] == dsadc_pkg::result_offset;
    assign start_ev = (ctrl_wr && apb_req.pwdata[0])
        || (start_trig && !trig_q);
    always_ff @(posedge sys_clk) begin
        trig_q <= start_trig;
        if (rst) begin
            mode <= 2'h0;
            res <= 2'h0;
            decim <= dsadc_pkg::decim_reset;
            since <= 0;
        end else begin
            if (ctrl_wr) begin
                mode <= apb_req.pwdata[2:1];
                res <= apb_req.pwdata[4:3];
            end
            if (wr_ok && apb_req.paddr[7:0] == dsadc_pkg::decim_offset) begin
                decim <= apb_req.pwdata[15:0];
            end
            // Saturates so a long idle spell cannot wrap around
            if (start_ev || $rose(conv_done)) begin
                since <= 1;
            end else if (since < 100000) begin
                since <= since + 1;
            end
        end
    end
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    reset_clear_a: assert property ($fell(rst) |->
        !conv_done && !mux_select) else $error("outputs not reset");
    done_hold_a: assert property (conv_done && !rd_first && !ctrl_wr
        |=> conv_done) else $error("done dropped before read");
    read_clear_a: assert property (rd_first && mode == 2'h0
        |=> !conv_done) else $error("done kept after read");
    single_lat_a: assert property ($rose(conv_done) && mode == 2'h0
        |-> since >= int'(decim) * 4 && since <= int'(decim) * 4 + 8)
        else $error("single result at wrong time");
    multi_gap_a: assert property ($rose(conv_done) && (mode == 2'h1
        || (mode == 2'h3 && res != 2'h3)) |-> since >= int'(decim) * 4)
        else $error("multi result too early");
    cont_gap_a: assert property ($rose(conv_done) && mode == 2'h2
        |-> since >= int'(decim)) else $error("continuous result too early");
    mux_follow_a: assert property (ctrl_wr |=> mux_select
        == $past(apb_req.pwdata[6])) else $error("mux select wrong");
    status_done_a: assert property (acc && apb_rsp.pready
        && !apb_req.pwrite
        && apb_req.paddr[7:0] == dsadc_pkg::status_offset
        |-> apb_rsp.prdata[0] == $past(conv_done))
        else $error("status done bit wrong");
    write_ready_a: assert property (acc && apb_req.pwrite
        |-> apb_rsp.pready) else $error("write not taken at once");
endmodule : dsadc_seq_props

bind dsadc_seq dsadc_seq_props #(.acc_width(acc_width)) dsadc_seq_props_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .mod_bit(mod_bit),
    .start_trig(start_trig),
    .conv_done(conv_done),
    .mux_select(mux_select)
);

// file: verification/dsadc_mod_model.sv
`timescale 1ns/1ps
module dsadc_mod_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] level,
    output logic mod_bit
);
    // ----------------
    // First-order loop
    // ----------------
    // Ones density tracks level/256, like a settled analog input
    logic [8:0] acc;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc <= 9'h000;
        end else begin
            acc <= {1'b0, acc[7:0]} + {1'b0, level};
        end
    end
    assign mod_bit = acc[8];
endmodule : dsadc_mod_model

// file: verification/dsadc_seq_test.sv
`timescale 1ns/1ps
module dsadc_seq_test;
    // ----------------
    // Bench signals
    // ----------------
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic start_trig = 1'b0;
    logic [7:0] level = 8'h90;
    logic mod_bit;
    logic conv_done;
    logic mux_select;
    dsadc_pkg::dsadc_apb_req_type apb_req = '0;
    dsadc_pkg::dsadc_apb_rsp_type apb_rsp;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [31:0] res [2];
    logic [31:0] cw [4] = '{32'h33, 32'h35, 32'h37, 32'h3f};
    int gap [4] = '{32, 8, 32, 8};
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    dsadc_seq #(.acc_width(32)) dsadc_seq_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .mod_bit(mod_bit),
        .start_trig(start_trig),
        .conv_done(conv_done),
        .mux_select(mux_select)
    );
    dsadc_mod_model dsadc_mod_model_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .level(level),
        .mod_bit(mod_bit)
    );
    // ----------------
    // Tasks
    // ----------------
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string name, input logic [31:0] seen,
            input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    task automatic xfer(input logic wr, input logic [7:0] addr,
            input logic [31:0] wdata, output logic [31:0] rdata);
        int n;
        @(posedge sys_clk);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= {24'h0, addr};
        apb_req.pwdata <= wdata;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        // Sample mid-cycle, where pready and prdata have settled
        do begin
            @(negedge sys_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (apb_rsp.pready !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
        rdata = apb_rsp.prdata;
        check("pslverr", apb_rsp.pslverr, 32'h0);
        @(posedge sys_clk);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : xfer
    task automatic wait_done(output int t);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (conv_done !== 1'b1 && n < 3000);
        if (conv_done !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
        t = cyc;
    endtask : wait_done
    // ----------------
    // Sequence
    // ----------------
    initial begin
        int t0;
        int t1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        check("conv_done", conv_done, 32'h0);
        xfer(1'b0, dsadc_pkg::ctrl_offset, 32'h0, rd);
        check("ctrl", rd, dsadc_pkg::ctrl_reset);
        xfer(1'b0, dsadc_pkg::decim_offset, 32'h0, rd);
        check("decim", rd, {16'h0, dsadc_pkg::decim_reset});
        xfer(1'b0, dsadc_pkg::status_offset, 32'h0, rd);
        check("status", rd & 32'h5, 32'h0);
        xfer(1'b0, 8'h10, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        // Both levels above mid-scale so any result format stays ordered
        for (int i = 0; i < 2; i++) begin
            level <= i == 0 ? 8'h90 : 8'hf0;
            xfer(1'b1, dsadc_pkg::ctrl_offset, 32'h39, rd);
            t0 = cyc;
            wait_done(t1);
            check("latency", t1 - t0 >= 256, 32'h1);
            xfer(1'b0, dsadc_pkg::status_offset, 32'h0, rd);
            check("done bit", rd[0], 32'h1);
            xfer(1'b0, dsadc_pkg::result_offset, 32'h0, res[i]);
            check("conv_done", conv_done, 32'h0);
            repeat (400) @(posedge sys_clk);
            check("standby", conv_done, 32'h0);
        end
        check("result order", res[1] > res[0], 32'h1);
        xfer(1'b1, dsadc_pkg::ctrl_offset, 32'h38, rd);
        start_trig <= 1'b1;
        repeat (4) @(posedge sys_clk);
        start_trig <= 1'b0;
        wait_done(t1);
        check("trigger", conv_done, 32'h1);
        xfer(1'b0, dsadc_pkg::result_offset, 32'h0, rd);
        xfer(1'b1, dsadc_pkg::decim_offset, 32'h8, rd);
        // Trigger stays idle and the mux untouched in the multi, continuous and both turbo runs
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, dsadc_pkg::ctrl_offset, cw[m], rd);
            wait_done(t0);
            xfer(1'b0, dsadc_pkg::result_offset, 32'h0, rd);
            wait_done(t1);
            check("period", t1 - t0 >= gap[m] && t1 - t0 <= gap[m] + 2,
                32'h1);
            xfer(1'b1, dsadc_pkg::ctrl_offset, 32'h0, rd);
            xfer(1'b0, dsadc_pkg::result_offset, 32'h0, rd);
        end
        xfer(1'b1, dsadc_pkg::ctrl_offset, 32'h73, rd);
        #1;
        check("mux_select", mux_select, 32'h1);
        for (int k = 0; k < 5; k++) begin
            wait_done(t1);
            xfer(1'b0, dsadc_pkg::status_offset, 32'h0, rd);
            check("valid", rd[1], k != 0);
            xfer(1'b0, dsadc_pkg::result_offset, 32'h0, rd);
        end
        give_verdict();
    end
endmodule : dsadc_seq_test
